// file: shared/fsp_pkg.sv
// Package: constants and carriers for the flash self-program sequencer
package fsp_pkg;
  localparam int unsigned CLK_MHZ         = 250;
  // Calibrated oscillator, kept as a separate tick input
  localparam int unsigned PROG_MIN_US     = 3700;
  localparam int unsigned PROG_MAX_US     = 4500;
  localparam int unsigned OSC_KHZ         = 128;
  localparam int unsigned PROG_TICKS      = (PROG_MIN_US * OSC_KHZ + 999) / 1000;
  localparam logic [15:0] PROG_TICKS_W    = 16'(PROG_TICKS);
  localparam logic [2:0]  STORE_WIN       = 3'h4;
  localparam logic [2:0]  LOAD_WIN        = 3'h3;
  localparam int unsigned WORD_BITS       = 5;
  localparam logic [4:0]  CMD_BUF_LOAD    = 5'h01;
  localparam logic [4:0]  CMD_PAGE_ERASE  = 5'h03;
  localparam logic [4:0]  CMD_PAGE_WRITE  = 5'h05;
  localparam logic [4:0]  CMD_FUSE_READ   = 5'h09;
  localparam logic [4:0]  CMD_SECT_REEN   = 5'h11;
  localparam logic [15:0] Z_FUSE_LOW      = 16'h0000;
  localparam logic [15:0] Z_LOCK          = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT      = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH     = 16'h0003;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [7:0]  BYTE_ONES       = 8'hFF;

  typedef enum logic [2:0] {
    FSP_IDLE, FSP_ARM_STORE, FSP_ARM_READ, FSP_BUSY_ERASE, FSP_BUSY_WRITE
  } fsp_state_t;

  typedef struct packed {
    logic [10:0] page;
    logic [4:0]  word;
  } fsp_addr_t;

  typedef struct packed {
    fsp_state_t  st;
    logic [2:0]  win;
    logic [15:0] ticks;
    fsp_addr_t   addr;
    logic        self_prog_enable;
    logic        lock_fuse_read_select;
    logic        page_erase_cmd;
    logic        page_write_cmd;
    logic        cpu_stall;
    logic        erase_pulse;
    logic        write_pulse;
    logic        buf_load_pulse;
    logic        buf_clear_pulse;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        rd_flash;
    logic [15:0] rd_addr;
  } fsp_regs_t;
endpackage

// file: rtl/fsp_seq.sv
// Flash self-program sequencer: addressing, fuse readback, timed erase/write
`timescale 1ns/1ps
// Summary of operation
// - Store-program address comes from 16-bit Z pointer (high and low bytes).
// - Low word-address bits select word in page, high bits select page.
// - Load-program uses Z as byte address; bit 0 picks low or high byte.
// - Pending EEPROM write blocks all flash programming commands.
// - Pending EEPROM write also suppresses fuse and lock readback.
// - Armed readback with Z 0x0001 and load within three cycles returns lock.
// - Enable bits clear on readback, three idle load or four idle store cycles.
// - With both bits clear load-program reads ordinary flash bytes.
// - Armed readback with Z 0x0000 returns low fuse byte.
// - Armed readback with Z 0x0003 returns high fuse byte.
// - Armed readback with Z 0x0002 returns extended fuse byte.
// - Programmed fuse or lock bits read zero, unprogrammed read one.
// - Reset during erase or write lets the operation finish.
// - Erase or write lasts 3.7 to 4.5 ms on oscillator time.
// - Section-busy flag always reads zero on this variant.
// - Patterns 03 erase, 01 buffer load, 05 write; store within four cycles.
// - Page buffer clears after page write, read-enable write and a reset outside erase or write.
// - CPU is stalled for the whole page erase or page write.
module fsp_seq (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        osc_tick,
  input  wire logic        ctrl_wr,
  input  wire logic [4:0]  ctrl_wdata,
  input  wire logic        store_prog,
  input  wire logic        load_prog,
  input  wire logic [7:0]  z_high,
  input  wire logic [7:0]  z_low,
  input  wire logic        eeprom_prog_enable,
  input  wire logic [7:0]  fuse_low_byte,
  input  wire logic [7:0]  fuse_high_byte,
  input  wire logic [7:0]  fuse_extended_byte,
  input  wire logic [7:0]  lock_byte,
  input  wire logic [7:0]  flash_rd_byte,
  output logic             self_prog_enable,
  output logic             lock_fuse_read_select,
  output logic             page_erase_cmd,
  output logic             page_write_cmd,
  output logic             section_busy_flag,
  output logic             cpu_stall,
  output logic             erase_pulse,
  output logic             write_pulse,
  output logic             buf_load_pulse,
  output logic             buf_clear_pulse,
  output logic [10:0]      page_number_field,
  output logic [4:0]       word_in_page_field,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             rd_flash,
  output logic [15:0]      rd_addr
);
  fsp_pkg::fsp_regs_t r_q, r_d;
  logic [15:0]        z_ptr;
  logic               busy;

  assign z_ptr = {z_high, z_low};
  assign busy  = (r_q.st == fsp_pkg::FSP_BUSY_ERASE) || (r_q.st == fsp_pkg::FSP_BUSY_WRITE);

  always_comb begin
    r_d                 = r_q;
    r_d.erase_pulse     = 1'b0;
    r_d.write_pulse     = 1'b0;
    r_d.buf_load_pulse  = 1'b0;
    r_d.buf_clear_pulse = 1'b0;
    r_d.rd_valid        = 1'b0;
    r_d.rd_flash        = 1'b0;
    case (r_q.st)
      fsp_pkg::FSP_IDLE: begin
        if (ctrl_wr && !eeprom_prog_enable) begin
          case (ctrl_wdata)
            fsp_pkg::CMD_BUF_LOAD, fsp_pkg::CMD_PAGE_ERASE, fsp_pkg::CMD_PAGE_WRITE: begin
              r_d.st               = fsp_pkg::FSP_ARM_STORE;
              r_d.win              = fsp_pkg::STORE_WIN;
              r_d.self_prog_enable = 1'b1;
              r_d.page_erase_cmd   = (ctrl_wdata == fsp_pkg::CMD_PAGE_ERASE);
              r_d.page_write_cmd   = (ctrl_wdata == fsp_pkg::CMD_PAGE_WRITE);
            end
            fsp_pkg::CMD_FUSE_READ: begin
              r_d.st                    = fsp_pkg::FSP_ARM_READ;
              r_d.win                   = fsp_pkg::LOAD_WIN;
              r_d.self_prog_enable      = 1'b1;
              r_d.lock_fuse_read_select = 1'b1;
            end
            fsp_pkg::CMD_SECT_REEN: r_d.buf_clear_pulse = 1'b1;
            default: ;
          endcase
        end
        // plain flash byte read, byte addressing
        if (load_prog) begin
          r_d.rd_flash = 1'b1;
          r_d.rd_addr  = z_ptr;
        end
      end
      fsp_pkg::FSP_ARM_STORE: begin
        r_d.win = r_q.win - 3'h1;
        if (store_prog && !eeprom_prog_enable) begin
          r_d.addr = fsp_pkg::fsp_addr_t'({1'b0, z_ptr[15:1]});
          if (r_q.page_erase_cmd || r_q.page_write_cmd) begin
            r_d.st          = r_q.page_erase_cmd ? fsp_pkg::FSP_BUSY_ERASE
                                                 : fsp_pkg::FSP_BUSY_WRITE;
            r_d.ticks       = fsp_pkg::PROG_TICKS_W;
            r_d.erase_pulse = r_q.page_erase_cmd;
            r_d.write_pulse = r_q.page_write_cmd;
            r_d.cpu_stall   = 1'b1;
          end else begin
            r_d.buf_load_pulse   = 1'b1;
            r_d.st               = fsp_pkg::FSP_IDLE;
            r_d.self_prog_enable = 1'b0;
          end
        end else if (r_q.win == 3'h1) begin
          r_d.st               = fsp_pkg::FSP_IDLE;
          r_d.self_prog_enable = 1'b0;
          r_d.page_erase_cmd   = 1'b0;
          r_d.page_write_cmd   = 1'b0;
        end
      end
      fsp_pkg::FSP_ARM_READ: begin
        r_d.win = r_q.win - 3'h1;
        if (load_prog && !eeprom_prog_enable) begin
          r_d.rd_valid = 1'b1;
          r_d.rd_addr  = z_ptr;
          // raw bytes, programmed bits already zero
          case (z_ptr)
            fsp_pkg::Z_FUSE_LOW:  r_d.rd_data = fuse_low_byte;
            fsp_pkg::Z_LOCK:      r_d.rd_data = lock_byte;
            fsp_pkg::Z_FUSE_EXT:  r_d.rd_data = fuse_extended_byte;
            fsp_pkg::Z_FUSE_HIGH: r_d.rd_data = fuse_high_byte;
            default:              r_d.rd_data = fsp_pkg::BYTE_ONES;
          endcase
        end
        if ((load_prog && !eeprom_prog_enable) || r_q.win == 3'h1) begin
          r_d.st                    = fsp_pkg::FSP_IDLE;
          r_d.self_prog_enable      = 1'b0;
          r_d.lock_fuse_read_select = 1'b0;
        end
      end
      fsp_pkg::FSP_BUSY_ERASE, fsp_pkg::FSP_BUSY_WRITE: begin
        if (osc_tick) begin
          r_d.ticks = r_q.ticks - 16'h0001;
        end
        if (osc_tick && r_q.ticks == 16'h0001) begin
          r_d.st               = fsp_pkg::FSP_IDLE;
          r_d.self_prog_enable = 1'b0;
          r_d.page_erase_cmd   = 1'b0;
          r_d.page_write_cmd   = 1'b0;
          r_d.cpu_stall        = 1'b0;
          r_d.buf_clear_pulse  = (r_q.st == fsp_pkg::FSP_BUSY_WRITE);
        end
      end
      default: r_d.st = fsp_pkg::FSP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // a running erase or write survives reset
      if (!busy) begin
        r_q                 <= '0;
        r_q.st              <= fsp_pkg::FSP_IDLE;
        r_q.buf_clear_pulse <= 1'b1;
      end else begin
        r_q <= r_d;
      end
    end else begin
      r_q <= r_d;
    end
  end

  assign self_prog_enable      = r_q.self_prog_enable;
  assign lock_fuse_read_select = r_q.lock_fuse_read_select;
  assign page_erase_cmd        = r_q.page_erase_cmd;
  assign page_write_cmd        = r_q.page_write_cmd;
  assign section_busy_flag     = 1'b0;
  assign cpu_stall             = r_q.cpu_stall;
  assign erase_pulse           = r_q.erase_pulse;
  assign write_pulse           = r_q.write_pulse;
  assign buf_load_pulse        = r_q.buf_load_pulse;
  assign buf_clear_pulse       = r_q.buf_clear_pulse;
  assign page_number_field     = r_q.addr.page;
  assign word_in_page_field    = r_q.addr.word;
  assign rd_data               = r_q.rd_data;
  assign rd_valid              = r_q.rd_valid;
  assign rd_flash              = r_q.rd_flash;
  assign rd_addr               = r_q.rd_addr;

  // First cycle of the store window, seen from the registered state
  sequence s_store_armed;
    $rose(self_prog_enable) && r_q.st == fsp_pkg::FSP_ARM_STORE;
  endsequence

  sequence s_no_store;
    (!store_prog)[*4];
  endsequence

  property p_store_window;
    @(posedge sys_clk) disable iff (rst)
    (s_store_armed ##0 s_no_store) |=> !self_prog_enable;
  endproperty
  a_store_window: assert property (p_store_window) else $error("store window overrun");

  property p_eeprom_block;
    @(posedge sys_clk) disable iff (rst)
    (r_q.st == fsp_pkg::FSP_IDLE && ctrl_wr && eeprom_prog_enable) |=> !self_prog_enable;
  endproperty
  a_eeprom_block: assert property (p_eeprom_block) else $error("control accepted in EEPROM write");

  property p_fuse_suppress;
    @(posedge sys_clk) disable iff (rst)
    eeprom_prog_enable |=> !rd_valid;
  endproperty
  a_fuse_suppress: assert property (p_fuse_suppress) else $error("readback during EEPROM write");

  property p_lock_read;
    @(posedge sys_clk) disable iff (rst)
    (r_q.st == fsp_pkg::FSP_ARM_READ && load_prog && !eeprom_prog_enable
     && z_ptr == fsp_pkg::Z_LOCK) |=> (rd_valid && rd_data == $past(lock_byte)
     && !self_prog_enable && !lock_fuse_read_select);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock byte readback wrong");

  property p_fuse_low;
    @(posedge sys_clk) disable iff (rst)
    (r_q.st == fsp_pkg::FSP_ARM_READ && load_prog && !eeprom_prog_enable
     && z_ptr == fsp_pkg::Z_FUSE_LOW) |=> rd_data == $past(fuse_low_byte);
  endproperty
  a_fuse_low: assert property (p_fuse_low) else $error("low fuse readback wrong");

  property p_stall_hold;
    @(posedge sys_clk) disable iff (rst)
    $rose(cpu_stall) |-> (cpu_stall && self_prog_enable)[*8];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");

  property p_busy_flag;
    @(posedge sys_clk) section_busy_flag == 1'b0;
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("section busy set");

  property p_flash_read;
    @(posedge sys_clk) disable iff (rst)
    (r_q.st == fsp_pkg::FSP_IDLE && load_prog) |=> (rd_flash && rd_addr == $past(z_ptr));
  endproperty
  a_flash_read: assert property (p_flash_read) else $error("plain flash read missing");
endmodule // fsp_seq

// file: verification/fsp_cpu_model.sv
// CPU core model issuing control writes, store-program and load-program operations
`timescale 1ns/1ps
module fsp_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       self_prog_enable,
  input  wire logic       eeprom_prog_enable,
  output logic            ctrl_wr,
  output logic [4:0]      ctrl_wdata,
  output logic            store_prog,
  output logic            load_prog,
  output logic [7:0]      z_high,
  output logic [7:0]      z_low
);
  initial begin
    ctrl_wr    = 1'b0;
    ctrl_wdata = 5'h00;
    store_prog = 1'b0;
    load_prog  = 1'b0;
    z_high     = 8'h00;
    z_low      = 8'h00;
  end

  task automatic set_z(input logic [15:0] z);
    @(negedge sys_clk);
    {z_high, z_low} = z;
  endtask

  // poll eeprom and enable; skipped only when a refusal is wanted
  task automatic ctrl_write(input logic [4:0] v, input bit poll);
    int i;
    for (i = 0; i < 30000 && poll && (self_prog_enable !== 1'b0 ||
         eeprom_prog_enable !== 1'b0); i++) @(negedge sys_clk);
    @(negedge sys_clk);
    ctrl_wr    = 1'b1;
    ctrl_wdata = v;
    @(negedge sys_clk);
    ctrl_wr = 1'b0;
  endtask

  // store issued straight after the control write, no gap
  task automatic store();
    store_prog = 1'b1;
    @(negedge sys_clk);
    store_prog = 1'b0;
  endtask

  task automatic load();
    load_prog = 1'b1;
    @(negedge sys_clk);
    load_prog = 1'b0;
  endtask
endmodule // fsp_cpu_model

// file: verification/tb.sv
// Testbench for the flash self-program sequencer
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0, rst = 1'b1, osc_tick = 1'b0, eeprom_prog_enable = 1'b0;
  logic [7:0] fuse_low_byte = 8'hE2, fuse_high_byte = 8'hDF, fuse_extended_byte = 8'hF9;
  logic [7:0] lock_byte = 8'h3C, flash_rd_byte = 8'hA5, rd_data, z_high, z_low;
  logic self_prog_enable, lock_fuse_read_select, page_erase_cmd, page_write_cmd;
  logic section_busy_flag, cpu_stall, erase_pulse, write_pulse, buf_load_pulse;
  logic buf_clear_pulse, rd_valid, rd_flash, ctrl_wr, store_prog, load_prog, clr_seen;
  logic [10:0] page_number_field;
  logic [4:0]  word_in_page_field, ctrl_wdata;
  logic [15:0] rd_addr, z;
  logic [7:0]  fuse_exp [4];
  int n_errors = 0, check_count = 0, osc_cnt = 0, n;

  always #2 sys_clk = ~sys_clk;
  // Fast oscillator tick keeps each timed operation near 7600 clocks
  always @(negedge sys_clk) begin
    osc_cnt  <= osc_cnt + 1;
    osc_tick <= (osc_cnt % 16 == 15);
  end
  always @(posedge sys_clk) if (buf_clear_pulse === 1'b1) clr_seen <= 1'b1;

  fsp_seq u_fsp_seq (.sys_clk, .rst, .osc_tick, .ctrl_wr, .ctrl_wdata, .store_prog,
    .load_prog, .z_high, .z_low, .eeprom_prog_enable, .fuse_low_byte, .fuse_high_byte,
    .fuse_extended_byte, .lock_byte, .flash_rd_byte, .self_prog_enable,
    .lock_fuse_read_select, .page_erase_cmd, .page_write_cmd, .section_busy_flag,
    .cpu_stall, .erase_pulse, .write_pulse, .buf_load_pulse, .buf_clear_pulse,
    .page_number_field, .word_in_page_field, .rd_data, .rd_valid, .rd_flash, .rd_addr);
  fsp_cpu_model u_fsp_cpu_model (.sys_clk, .self_prog_enable, .eeprom_prog_enable,
    .ctrl_wr, .ctrl_wdata, .store_prog, .load_prog, .z_high, .z_low);

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Counts oscillator ticks while busy; optionally pulses reset in mid-operation
  task automatic wait_done(input bit hit_rst);
    int i;
    n = 0;
    for (i = 0; i < 20000 && self_prog_enable === 1'b1; i++) begin
      @(posedge sys_clk);
      n += int'(osc_tick);
      @(negedge sys_clk);
      if (hit_rst && i == 50) rst = 1'b1;
      if (hit_rst && i == 53) rst = 1'b0;
      if (hit_rst && i == 54) chk("busy_thru_rst", 16'h0001, 16'(self_prog_enable));
    end
    // duration within the documented window in oscillator ticks
    chk("ticks", 16'h0001, 16'(n >= fsp_pkg::PROG_TICKS &&
        n <= fsp_pkg::PROG_MAX_US * fsp_pkg::OSC_KHZ / 1000));
    chk("stall_end", 16'h0000, 16'(cpu_stall));
    chk("cmd_end", 16'h0000, 16'({page_erase_cmd, page_write_cmd, self_prog_enable}));
  endtask

  initial begin
    fuse_exp = '{fuse_low_byte, lock_byte, fuse_extended_byte, fuse_high_byte};
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    chk("clear_at_reset", 16'h0001, 16'(buf_clear_pulse));
    chk("busy_flag", 16'h0000, 16'(section_busy_flag));
    chk("enable_rst", 16'h0000, 16'(self_prog_enable));
    for (int k = 0; k < 4; k++) begin
      u_fsp_cpu_model.set_z(16'(k));
      u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_FUSE_READ, 1'b1);
      u_fsp_cpu_model.load();
      chk("rd_valid", 16'h0001, 16'(rd_valid));
      chk("rd_data", 16'(fuse_exp[k]), 16'(rd_data));
      chk("bits_clear", 16'h0000, 16'({self_prog_enable, lock_fuse_read_select}));
    end
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_FUSE_READ, 1'b1);
    repeat (6) @(negedge sys_clk);
    chk("read_timeout", 16'h0000, 16'({self_prog_enable, lock_fuse_read_select}));
    u_fsp_cpu_model.set_z(16'h0123);
    u_fsp_cpu_model.load();
    chk("plain_read", 16'h0001, 16'(rd_flash));
    chk("byte_addr", 16'h0123, rd_addr);
    // Readback is armed first, so only the EEPROM write can hold it back
    u_fsp_cpu_model.set_z(fsp_pkg::Z_LOCK);
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_FUSE_READ, 1'b1);
    eeprom_prog_enable = 1'b1;
    u_fsp_cpu_model.load();
    chk("ee_no_fuse", 16'h0000, 16'(rd_valid));
    repeat (4) @(negedge sys_clk);
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_PAGE_ERASE, 1'b0);
    u_fsp_cpu_model.store();
    chk("ee_block", 16'h0000, 16'({self_prog_enable, erase_pulse, cpu_stall}));
    eeprom_prog_enable = 1'b0;
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_BUF_LOAD, 1'b1);
    repeat (6) @(negedge sys_clk);
    chk("store_timeout", 16'h0000, 16'(self_prog_enable));
    z = 16'h1234;
    u_fsp_cpu_model.set_z(z);
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_BUF_LOAD, 1'b1);
    u_fsp_cpu_model.store();
    chk("buf_load", 16'h0001, 16'(buf_load_pulse));
    chk("word_field", 16'(z[5:1]), 16'(word_in_page_field));
    chk("page_field", 16'(z[15:6]), 16'(page_number_field));
    clr_seen = 1'b0;
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_SECT_REEN, 1'b1);
    u_fsp_cpu_model.store();
    @(negedge sys_clk);
    chk("reen_clear", 16'h0001, 16'(clr_seen));
    // erase and write share one page address
    u_fsp_cpu_model.set_z(16'h1240);
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_PAGE_ERASE, 1'b1);
    u_fsp_cpu_model.store();
    chk("erase", 16'h000F, 16'({erase_pulse, cpu_stall, self_prog_enable, page_erase_cmd}));
    chk("erase_page", 16'h0049, 16'(page_number_field));
    wait_done(1'b0);
    clr_seen = 1'b0;
    u_fsp_cpu_model.ctrl_write(fsp_pkg::CMD_PAGE_WRITE, 1'b1);
    u_fsp_cpu_model.store();
    chk("write", 16'h000F, 16'({write_pulse, cpu_stall, self_prog_enable, page_write_cmd}));
    chk("write_page", 16'h0049, 16'(page_number_field));
    wait_done(1'b1);
    repeat (2) @(negedge sys_clk);
    chk("write_clear", 16'h0001, 16'(clr_seen));
    close_out();
  end

  initial begin
    #240_000;
    n_errors++;
    close_out();
  end
endmodule // tb
